// >>> src/api_pkg.sv
/*
 package of the audio port interrupt logic: register offsets, flag
 positions, reset values.
 assumes the register access port of the audio block reaches it.
*/
package api_pkg;
   localparam int          ADDR_W           = 12;
   localparam int          NUM_FLAGS        = 14;
   // raw source register offset, kept at the start of the map
   localparam logic [11:0] OFS_RAW_SOURCE   = 12'h0000;
   localparam logic [11:0] OFS_MASK         = 12'h0004;
   localparam logic [11:0] OFS_CLEAR        = 12'h0008;
   localparam logic [31:0] MASK_RESET       = 32'hFFFF_FFFF;
   localparam logic [31:0] RAW_RESET        = 32'h0000_0000;
   localparam int          BIT_MODEM_STATUS = 13;
   localparam int          BIT_READ_DONE    = 12;
   localparam int          BIT_WRITE_DONE   = 11;
   localparam int          BIT_CODEC_READY  = 10;
   localparam int          BIT_EXT_IN_ERR   = 9;
   localparam int          BIT_EXT_OUT_ERR  = 8;
   localparam int          BIT_BUS_POP_ERR  = 7;
   localparam int          BIT_BUS_PUSH_ERR = 6;
   localparam int          BIT_IN_FULL      = 5;
   localparam int          BIT_IN_THRESH    = 4;
   localparam int          BIT_IN_DATA      = 3;
   localparam int          BIT_OUT_SPACE    = 2;
   localparam int          BIT_OUT_LOW      = 1;
   localparam int          BIT_OUT_DRAINED  = 0;
   // byte pointer of a fifo word, 0 when aligned
   localparam logic [1:0]  BYTE_ZERO        = 2'h0;
   localparam logic [1:0]  SIZE_BYTE        = 2'h0;
   localparam logic [1:0]  SIZE_HALF        = 2'h1;
   localparam logic [1:0]  SIZE_WORD        = 2'h2;
endpackage

// >>> src/api_irq.sv
/*
 interrupt collection of an audio serial port: sticky raw flags,
 per-bit mask, write-one-to-clear, one level interrupt output.
 assumes fifo, serializer and ac97 slot logic supply one-cycle event
 pulses and levels in this clock domain; register accesses are one
 cycle strobes of 32-bit words.
*/
`timescale 1ns/100ps

// Operation
// - ac97 mode: set bit 12 when codec register read data is ready
// - ac97 mode: set bit 11 when codec register write completes
// - set bit 10 on codec-ready tag bit rising 0 to 1
// - set bit 9 on external-side in-queue overrun or misaligned access
// - set bit 8 on external-side out-queue underrun or misaligned access
// - set bit 7 on bus-side in-queue underrun or misaligned read
// - set bit 6 on bus-side out-queue overrun or misaligned write
// - access misaligned when wider access finds byte pointer not at zero
// - set bit 5 when in-queue becomes full
// - set bit 4 when in-queue level rises above programmed threshold
// - set bit 3 when in-queue goes from empty to holding data
// - set bit 2 when out-queue goes from full to having space
// - set bit 1 when out-queue level falls below programmed threshold
// - set bit 0 when out-queue becomes empty
// - mask bit one keeps its flag off the interrupt; all mask bits reset to one
// - writing one to clear register clears that flag; zero leaves it
// - ac97 flags set only while the port runs in ac97 mode
// - raw source register reads the unmasked flags
module api_irq #(
   parameter int LEVEL_W = 8
) (
   // clock and reset
   input  wire logic               clk_in,
   input  wire logic               sys_rst_in,
   // register access
   input  wire logic               reg_wr_in,
   input  wire logic               reg_rd_in,
   input  wire logic [11:0]        reg_addr_in,
   input  wire logic [31:0]        reg_wdata_in,
   output logic      [31:0]        reg_rdata_out,
   // mode
   input  wire logic               ac97_mode_in,
   // ac97 events
   input  wire logic               modem_status_valid_in,
   input  wire logic               cmd_read_done_in,
   input  wire logic               cmd_write_done_in,
   input  wire logic               codec_ready_tag_in,
   // external side queue errors
   input  wire logic               ext_in_overrun_in,
   input  wire logic               ext_in_misalign_in,
   input  wire logic               ext_out_underrun_in,
   input  wire logic               ext_out_misalign_in,
   // bus side queue accesses
   input  wire logic               bus_pop_in,
   input  wire logic               bus_pop_empty_in,
   input  wire logic [1:0]         bus_pop_size_in,
   input  wire logic [1:0]         in_byte_ptr_in,
   input  wire logic               bus_push_in,
   input  wire logic               bus_push_full_in,
   input  wire logic [1:0]         bus_push_size_in,
   input  wire logic [1:0]         out_byte_ptr_in,
   // queue levels
   input  wire logic               in_queue_full_in,
   input  wire logic               in_queue_empty_in,
   input  wire logic [LEVEL_W-1:0] in_level_in,
   input  wire logic [LEVEL_W-1:0] in_queue_threshold_in,
   input  wire logic               out_queue_full_in,
   input  wire logic               out_queue_empty_in,
   input  wire logic [LEVEL_W-1:0] out_level_in,
   input  wire logic [LEVEL_W-1:0] out_queue_low_in,
   // interrupt
   output logic                    irq_out
);

   localparam int NF = api_pkg::NUM_FLAGS;

   if (LEVEL_W < 1 || LEVEL_W > 16) begin : g_bad_width
      $error("LEVEL_W must lie in 1..16");
   end

   logic [NF-1:0]      raw_q;
   logic [NF-1:0]      raw_d;
   logic [NF-1:0]      set_ev;
   logic [NF-1:0]      clr_ev;
   logic [NF-1:0]      mask_q;
   logic               tag_q;
   logic               in_full_q;
   logic               in_above_q;
   logic               in_empty_q;
   logic               out_full_q;
   logic               out_below_q;
   logic               out_empty_q;
   logic               in_above;
   logic               out_below;
   logic               bus_pop_misalign;
   logic               bus_push_misalign;

   // an access wider than a byte needs the byte pointer at zero
   function automatic logic misaligned(input logic [1:0] size,
                                       input logic [1:0] ptr);
      misaligned = (size != api_pkg::SIZE_BYTE) &&
                   (ptr != api_pkg::BYTE_ZERO);
   endfunction

   assign bus_pop_misalign  = misaligned(bus_pop_size_in,
                                         in_byte_ptr_in);
   assign bus_push_misalign = misaligned(bus_push_size_in,
                                         out_byte_ptr_in);
   assign in_above  = in_level_in > in_queue_threshold_in;
   assign out_below = out_level_in < out_queue_low_in;

   // previous levels, for edge detection of the codec-ready tag and the queue conditions
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tag_q       <= 1'b0;
         in_full_q   <= 1'b0;
         in_above_q  <= 1'b0;
         in_empty_q  <= 1'b1;
         out_full_q  <= 1'b0;
         out_below_q <= 1'b0;
         out_empty_q <= 1'b1;
      end else begin
         tag_q       <= codec_ready_tag_in;
         in_full_q   <= in_queue_full_in;
         in_above_q  <= in_above;
         in_empty_q  <= in_queue_empty_in;
         out_full_q  <= out_queue_full_in;
         out_below_q <= out_below;
         out_empty_q <= out_queue_empty_in;
      end
   end

   always_comb begin
      set_ev = '0;
      // ac97 events are ignored in serial audio mode
      set_ev[api_pkg::BIT_MODEM_STATUS] = ac97_mode_in &
                                          modem_status_valid_in;
      set_ev[api_pkg::BIT_READ_DONE]    = ac97_mode_in &
                                          cmd_read_done_in;
      set_ev[api_pkg::BIT_WRITE_DONE]   = ac97_mode_in &
                                          cmd_write_done_in;
      set_ev[api_pkg::BIT_CODEC_READY]  = ac97_mode_in &
                                          codec_ready_tag_in &
                                          ~tag_q;
      set_ev[api_pkg::BIT_EXT_IN_ERR]   = ext_in_overrun_in |
                                          ext_in_misalign_in;
      set_ev[api_pkg::BIT_EXT_OUT_ERR]  = ext_out_underrun_in |
                                          ext_out_misalign_in;
      set_ev[api_pkg::BIT_BUS_POP_ERR]  = bus_pop_in &
                                          (bus_pop_empty_in |
                                           bus_pop_misalign);
      set_ev[api_pkg::BIT_BUS_PUSH_ERR] = bus_push_in &
                                          (bus_push_full_in |
                                           bus_push_misalign);
      set_ev[api_pkg::BIT_IN_FULL]      = in_queue_full_in &
                                          ~in_full_q;
      set_ev[api_pkg::BIT_IN_THRESH]    = in_above & ~in_above_q;
      set_ev[api_pkg::BIT_IN_DATA]      = ~in_queue_empty_in &
                                          in_empty_q;
      set_ev[api_pkg::BIT_OUT_SPACE]    = ~out_queue_full_in &
                                          out_full_q;
      set_ev[api_pkg::BIT_OUT_LOW]      = out_below & ~out_below_q;
      set_ev[api_pkg::BIT_OUT_DRAINED]  = out_queue_empty_in &
                                          ~out_empty_q;
   end

   // a full word write is assumed; narrower strobes are not decoded
   assign clr_ev = (reg_wr_in && reg_addr_in == api_pkg::OFS_CLEAR) ?
                   reg_wdata_in[NF-1:0] : '0;

   // set wins over a clear in the same cycle
   assign raw_d = (raw_q & ~clr_ev) | set_ev;

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         raw_q <= api_pkg::RAW_RESET[NF-1:0];
      end else begin
         raw_q <= raw_d;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mask_q <= api_pkg::MASK_RESET[NF-1:0];
      end else if (reg_wr_in && reg_addr_in == api_pkg::OFS_MASK) begin
         mask_q <= reg_wdata_in[NF-1:0];
      end
   end

   // read data registered; unmapped offsets and reserved raw bits read zero, reserved mask bits read one
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            api_pkg::OFS_RAW_SOURCE:
               reg_rdata_out <= {{(32-NF){1'b0}}, raw_q};
            api_pkg::OFS_MASK:
               reg_rdata_out <= {{(32-NF){1'b1}}, mask_q};
            default:
               reg_rdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // registered so the pin never glitches on decode
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(raw_d & ~mask_q);
      end
   end

   chk_irq_follows_flags: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      ##1 irq_out == |($past(raw_d) & ~$past(mask_q)))
      else $error("interrupt does not follow unmasked flags");

   chk_flag_sticky: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (raw_q[0] && clr_ev[0] == 1'b0) |=> raw_q[0])
      else $error("flag dropped without a clear");

   chk_clear_works: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (clr_ev[5] && !set_ev[5]) |=> !raw_q[5])
      else $error("clear did not reset the flag");

   chk_set_beats_clear: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (clr_ev[6] && set_ev[6]) |=> raw_q[6])
      else $error("event lost against clear");

   chk_ac97_mode_only: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (!ac97_mode_in && !raw_q[10]) |=> !raw_q[10])
      else $error("codec ready set outside ac97 mode");

   chk_codec_rise: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (ac97_mode_in && codec_ready_tag_in && !tag_q) |=> raw_q[10])
      else $error("codec ready rise missed");

   chk_read_done: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (ac97_mode_in && cmd_read_done_in) |=> raw_q[12])
      else $error("read complete missed");

   chk_misalign_push: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (bus_push_in && bus_push_size_in == api_pkg::SIZE_WORD &&
       out_byte_ptr_in != api_pkg::BYTE_ZERO) |=> raw_q[6])
      else $error("misaligned push not flagged");

   chk_in_data_edge: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      ($fell(in_queue_empty_in)) |=> raw_q[3])
      else $error("in-queue data event missed");

   chk_out_drained: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      ($rose(out_queue_empty_in)) |=> raw_q[0])
      else $error("out-queue drained event missed");

   chk_write_done: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (ac97_mode_in && cmd_write_done_in) |=> raw_q[api_pkg::BIT_WRITE_DONE])
      else $error("write complete missed");

   chk_ac97_cmd_quiet: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (!ac97_mode_in && raw_q[13:11] == '0) |=> raw_q[13:11] == '0)
      else $error("ac97 command flag set outside ac97 mode");

   chk_ext_in_err: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (ext_in_overrun_in || ext_in_misalign_in) |=>
         raw_q[api_pkg::BIT_EXT_IN_ERR])
      else $error("external in-queue error missed");

   chk_ext_out_err: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (ext_out_underrun_in || ext_out_misalign_in) |=>
         raw_q[api_pkg::BIT_EXT_OUT_ERR])
      else $error("external out-queue error missed");

   chk_pop_underrun: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (bus_pop_in && bus_pop_empty_in) |=> raw_q[api_pkg::BIT_BUS_POP_ERR])
      else $error("underrun pop not flagged");

   chk_push_overrun: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (bus_push_in && bus_push_full_in) |=>
         raw_q[api_pkg::BIT_BUS_PUSH_ERR])
      else $error("overrun push not flagged");

   // byte accesses can never be misaligned
   chk_byte_push_ok: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (bus_push_in && !bus_push_full_in &&
       bus_push_size_in == api_pkg::SIZE_BYTE &&
       !raw_q[api_pkg::BIT_BUS_PUSH_ERR]) |=>
         !raw_q[api_pkg::BIT_BUS_PUSH_ERR])
      else $error("byte push flagged as misaligned");

   chk_in_full_edge: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(in_queue_full_in) |=> raw_q[api_pkg::BIT_IN_FULL])
      else $error("in-queue full event missed");

   chk_in_thresh_edge: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(in_level_in > in_queue_threshold_in) |=>
         raw_q[api_pkg::BIT_IN_THRESH])
      else $error("in-queue threshold event missed");

   chk_out_space_edge: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $fell(out_queue_full_in) |=> raw_q[api_pkg::BIT_OUT_SPACE])
      else $error("out-queue space event missed");

   chk_out_low_edge: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(out_level_in < out_queue_low_in) |=>
         raw_q[api_pkg::BIT_OUT_LOW])
      else $error("out-queue low event missed");

   chk_mask_write: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (reg_wr_in && reg_addr_in == api_pkg::OFS_MASK) |=>
         mask_q == $past(reg_wdata_in[NF-1:0]))
      else $error("mask write lost");

   chk_irq_raise: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      ((|(raw_q & ~mask_q)) && clr_ev == '0) |=> irq_out)
      else $error("interrupt low with an unmasked flag set");

   chk_irq_drop: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      ((raw_q & ~mask_q) == '0 && set_ev == '0) |=> !irq_out)
      else $error("interrupt high with no unmasked flag");

   chk_raw_readback: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (reg_rd_in && reg_addr_in == api_pkg::OFS_RAW_SOURCE) |=>
         reg_rdata_out == {{(32-NF){1'b0}}, $past(raw_q)})
      else $error("raw source read does not show the flags");

endmodule

// >>> dv/tb_audio_port_irq_logic.sv
/*
 testbench of the audio port interrupt logic: a table of single events
 checked through the raw source register, then reset, misalignment,
 mask, clear and interrupt cases written out by hand.
 assumes api_pkg and api_irq are compiled before it.
*/
`timescale 1ns/100ps
module tb_audio_port_irq_logic;
   typedef struct packed {logic m; logic [15:0] s; logic [13:0] e;} api_row_s;
   logic        clk_in, sys_rst_in, wr, rd, ac97, irq, pop_e, push_f;
   logic [11:0] addr;
   logic [31:0] wdata, rdata;
   logic [7:0]  thr;
   logic [15:0] st;
   logic [1:0]  pop_sz, push_sz, in_ptr, out_ptr;
   int          err_total, samples_checked, cycles;
   // stimulus bit i drives one event input for one cycle
   api_row_s    rows [17] = '{
      '{1'b1, 16'h0001, 14'h2000}, '{1'b1, 16'h0002, 14'h1000},
      '{1'b1, 16'h0004, 14'h0800}, '{1'b1, 16'h0008, 14'h0400},
      '{1'b1, 16'h0010, 14'h0200}, '{1'b1, 16'h4000, 14'h0200},
      '{1'b1, 16'h0020, 14'h0100}, '{1'b1, 16'h8000, 14'h0100},
      '{1'b1, 16'h0040, 14'h0080}, '{1'b1, 16'h0080, 14'h0040},
      '{1'b1, 16'h0100, 14'h0020}, '{1'b1, 16'h0200, 14'h0010},
      '{1'b1, 16'h0400, 14'h0008}, '{1'b1, 16'h0800, 14'h0004},
      '{1'b1, 16'h1000, 14'h0002}, '{1'b1, 16'h2000, 14'h0001},
      '{1'b0, 16'h000F, 14'h0000}};

   api_irq #(.LEVEL_W(8)) DUT (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .ac97_mode_in(ac97),
      .modem_status_valid_in(st[0]), .cmd_read_done_in(st[1]),
      .cmd_write_done_in(st[2]), .codec_ready_tag_in(st[3]),
      .ext_in_overrun_in(st[4]), .ext_in_misalign_in(st[14]),
      .ext_out_underrun_in(st[5]), .ext_out_misalign_in(st[15]),
      .bus_pop_in(st[6]), .bus_pop_empty_in(pop_e),
      .bus_pop_size_in(pop_sz), .in_byte_ptr_in(in_ptr),
      .bus_push_in(st[7]), .bus_push_full_in(push_f),
      .bus_push_size_in(push_sz), .out_byte_ptr_in(out_ptr),
      .in_queue_full_in(st[8]), .in_queue_empty_in(~st[10]),
      .in_level_in(st[9] ? 8'h05 : 8'h00), .in_queue_threshold_in(thr),
      .out_queue_full_in(st[11]), .out_queue_empty_in(st[13]),
      .out_level_in(st[12] ? 8'h02 : 8'h08), .out_queue_low_in(thr),
      .irq_out(irq));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // ceiling well above the few hundred cycles the run needs
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(negedge clk_in);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_in);
      wr = 1'b0;
   endtask

   // read data is registered, so it is taken one edge after the strobe
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      @(negedge clk_in);
      addr = a;
      rd = 1'b1;
      @(negedge clk_in);
      rd = 1'b0;
      chk(rdata, e);
   endtask

   // two idle cycles let a falling-level event land before the read
   task automatic pulse(input logic [15:0] s);
      @(negedge clk_in);
      st = s;
      @(negedge clk_in);
      st = 16'h0000;
      repeat (2) @(negedge clk_in);
   endtask

   initial begin
      {wr, rd, ac97, st, addr, wdata, pop_sz, push_sz, in_ptr, out_ptr} = '0;
      {pop_e, push_f, sys_rst_in} = 3'b111;
      {err_total, samples_checked, cycles} = '0;
      thr = 8'h04;
      repeat (20) @(negedge clk_in);
      sys_rst_in = 1'b0;
      chk({31'h0, irq}, 32'h0000_0000);
      rd_chk(api_pkg::OFS_RAW_SOURCE, api_pkg::RAW_RESET);
      rd_chk(api_pkg::OFS_MASK, api_pkg::MASK_RESET);
      rd_chk(api_pkg::OFS_CLEAR, 32'h0000_0000);
      foreach (rows[i]) begin
         ac97 = rows[i].m;
         pulse(rows[i].s);
         rd_chk(api_pkg::OFS_RAW_SOURCE, {18'h0, rows[i].e});
         chk({31'h0, irq}, 32'h0000_0000);
         wr_reg(api_pkg::OFS_CLEAR, 32'h0000_3FFF);
         rd_chk(api_pkg::OFS_RAW_SOURCE, 32'h0000_0000);
      end
      // levels equal to the threshold are not crossings
      thr = 8'h05;
      pulse(16'h0200);
      thr = 8'h02;
      pulse(16'h1000);
      rd_chk(api_pkg::OFS_RAW_SOURCE, 32'h0000_0000);
      thr = 8'h04;
      // a byte push may leave the pointer odd; a wider one may not
      push_f = 1'b0;
      out_ptr = 2'h1;
      pulse(16'h0080);
      rd_chk(api_pkg::OFS_RAW_SOURCE, 32'h0000_0000);
      push_sz = api_pkg::SIZE_WORD;
      pulse(16'h0080);
      rd_chk(api_pkg::OFS_RAW_SOURCE, 32'h0000_0040);
      pop_e = 1'b0;
      pop_sz = api_pkg::SIZE_HALF;
      in_ptr = 2'h2;
      pulse(16'h0040);
      rd_chk(api_pkg::OFS_RAW_SOURCE, 32'h0000_00C0);
      wr_reg(api_pkg::OFS_CLEAR, 32'h0000_0040);
      rd_chk(api_pkg::OFS_RAW_SOURCE, 32'h0000_0080);
      // an event in the cycle of its own clear must survive
      @(negedge clk_in);
      addr = api_pkg::OFS_CLEAR;
      wdata = 32'h0000_00C0;
      wr = 1'b1;
      st = 16'h0080;
      @(negedge clk_in);
      wr = 1'b0;
      st = 16'h0000;
      rd_chk(api_pkg::OFS_RAW_SOURCE, 32'h0000_0040);
      wr_reg(api_pkg::OFS_CLEAR, 32'h0000_3FFF);
      ac97 = 1'b1;
      pulse(16'h0004);
      wr_reg(api_pkg::OFS_MASK, 32'hFFFF_F7FF);
      @(negedge clk_in);
      chk({31'h0, irq}, 32'h0000_0001);
      rd_chk(api_pkg::OFS_MASK, 32'hFFFF_F7FF);
      wr_reg(api_pkg::OFS_RAW_SOURCE, 32'h0000_0000);
      rd_chk(api_pkg::OFS_RAW_SOURCE, 32'h0000_0800);
      wr_reg(api_pkg::OFS_CLEAR, 32'h0000_0400);
      @(negedge clk_in);
      chk({31'h0, irq}, 32'h0000_0001);
      wr_reg(api_pkg::OFS_MASK, 32'hFFFF_FFFF);
      @(negedge clk_in);
      chk({31'h0, irq}, 32'h0000_0000);
      wr_reg(api_pkg::OFS_MASK, 32'h0000_0000);
      rd_chk(api_pkg::OFS_MASK, 32'hFFFF_C000);
      wr_reg(api_pkg::OFS_CLEAR, 32'h0000_0800);
      @(negedge clk_in);
      chk({31'h0, irq}, 32'h0000_0000);
      rd_chk(12'h00C, 32'h0000_0000);
      // reset in mid-run with an unmasked flag pending
      pulse(16'h0001);
      chk({31'h0, irq}, 32'h0000_0001);
      sys_rst_in = 1'b1;
      @(negedge clk_in);
      chk({31'h0, irq}, 32'h0000_0000);
      sys_rst_in = 1'b0;
      rd_chk(api_pkg::OFS_RAW_SOURCE, 32'h0000_0000);
      rd_chk(api_pkg::OFS_MASK, api_pkg::MASK_RESET);
      report_and_stop();
   end
endmodule
